// >>> operand_addr_pkg.sv
// Constants shared by the operand address generator and its helpers.
// Assumes one 40 MHz instruction clock and an active-low async reset.
package operand_addr_pkg;

  // ****************************************************************
  // Operand forms presented by the sequencer
  // ****************************************************************
  localparam logic [3:0] MODE_NONE      = 4'h0;
  localparam logic [3:0] MODE_RD_IP     = 4'h1;
  localparam logic [3:0] MODE_RD_OR     = 4'h2;
  localparam logic [3:0] MODE_WR_IP     = 4'h3;
  localparam logic [3:0] MODE_WR_OR     = 4'h4;
  localparam logic [3:0] MODE_LOAD_ADDR = 4'h5;
  localparam logic [3:0] MODE_IND       = 4'h6;
  localparam logic [3:0] MODE_IND_CONST = 4'h7;
  localparam logic [3:0] MODE_IND_OR    = 4'h8;
  localparam logic [3:0] MODE_POST_INC1 = 4'h9;
  localparam logic [3:0] MODE_POST_INC2 = 4'hA;
  localparam logic [3:0] MODE_PRE_DEC1  = 4'hB;
  localparam logic [3:0] MODE_PRE_DEC2  = 4'hC;
  localparam logic [3:0] MODE_IMM       = 4'hD;

  // ****************************************************************
  // Immediate constant forms
  // ****************************************************************
  localparam logic [1:0] IMM_UBIN   = 2'h0;
  localparam logic [1:0] IMM_SDEC   = 2'h1;
  localparam logic [1:0] IMM_UDEC   = 2'h2;
  localparam logic [1:0] IMM_PACKED = 2'h3;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int          REG_COUNT   = 16;
  localparam int          SEL_W       = 4;
  localparam int          CONST_OFF_W = 12;
  localparam int          HALF_W      = 16;
  localparam int          DATA_W      = 32;
  localparam int          BCD_DIGITS  = 8;
  localparam logic [31:0] PTR_RST     = 32'h0000_0000;
  localparam logic [31:0] DATA_RST    = 32'h0000_0000;
  localparam logic [1:0]  STEP_ONE    = 2'h1;
  localparam logic [1:0]  STEP_TWO    = 2'h2;

endpackage

// >>> packed_decimal_check.sv
// Checks that every nibble of a packed-decimal value is a digit 0 to 9.
// Assumes a purely combinational use inside the clocked parent.
`timescale 1ns/1ps

module packed_decimal_check #(
  parameter int DIGITS = 8
) (
  input  wire logic [4*DIGITS-1:0] value_in,
  output logic                     digits_ok_out
);

  logic [DIGITS-1:0] digit_ok;

  // ****************************************************************
  // Per-digit range check
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_digit
      assign digit_ok[g] = (value_in[4*g +: 4] <= 4'h9);
    end
  endgenerate

  assign digits_ok_out = &digit_ok;

endmodule

// >>> operand_address_generator.sv
// Operand address generator: index pointers, offset registers,
// indirect address forms and immediate constant checking.
// Assumes the instruction sequencer drives all requests on sys_clk_in.
//
// Behaviour
// - Sixteen pointers and sixteen offset registers are reached by number.
// - Load-address writes the named location's address into the pointer.
// - A plain indirect operand uses the pointer's content as address.
// - A constant-offset operand adds a signed -2048..+2047 to the pointer.
// - A register-offset operand adds the signed offset register.
// - Post-increment uses the pointer, then adds one or two to it.
// - Decrement subtracts one or two first and uses the new value.
// - Binary immediates are taken as 16-bit or 32-bit values.
// - Packed-decimal immediates are flagged unless every digit is 0 to 9.
`timescale 1ns/1ps

module operand_address_generator
  import operand_addr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic                               sys_clk_in,
  input  wire logic                               rst_n_in,
  input  wire logic                               req_in,
  input  wire logic [3:0]                         mode_in,
  input  wire logic [operand_addr_pkg::SEL_W-1:0] ip_sel_in,
  input  wire logic [operand_addr_pkg::SEL_W-1:0] or_sel_in,
  input  wire logic [operand_addr_pkg::CONST_OFF_W-1:0] const_off_in,
  input  wire logic [ADDR_W-1:0]                  location_addr_in,
  input  wire logic [ADDR_W-1:0]                  wdata_in,
  input  wire logic [operand_addr_pkg::DATA_W-1:0] imm_in,
  input  wire logic [1:0]                         imm_form_in,
  input  wire logic                               imm_wide_in,
  output logic                                    done_out,
  output logic                                    addr_valid_out,
  output logic [ADDR_W-1:0]                       addr_out,
  output logic [operand_addr_pkg::DATA_W-1:0]     data_out,
  output logic                                    imm_err_out
);

  import operand_addr_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  generate
    if (ADDR_W < HALF_W || ADDR_W > DATA_W) begin : g_bad_width
      $error("ADDR_W must lie between 16 and 32");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  logic [ADDR_W-1:0] ip_r   [REG_COUNT];
  logic [ADDR_W-1:0] ip_nxt [REG_COUNT];
  logic [ADDR_W-1:0] or_r   [REG_COUNT];
  logic [ADDR_W-1:0] or_nxt [REG_COUNT];
  logic              done_r;
  logic              done_nxt;
  logic              addr_valid_r;
  logic              addr_valid_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_nxt;
  logic              imm_err_r;
  logic              imm_err_nxt;

  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] const_ext;
  logic [ADDR_W-1:0] step_one;
  logic [ADDR_W-1:0] step_two;
  logic [DATA_W-1:0] bcd_view;
  logic              bcd_ok;

  // Step size widened to the pointer width
  function automatic logic [ADDR_W-1:0] widen_step(input logic [1:0] s);
    widen_step = {{(ADDR_W-2){1'b0}}, s};
  endfunction

  assign ptr       = ip_r[ip_sel_in];
  assign const_ext = {{(ADDR_W-CONST_OFF_W){const_off_in[CONST_OFF_W-1]}},
                      const_off_in};
  assign step_one  = widen_step(STEP_ONE);
  assign step_two  = widen_step(STEP_TWO);

  // ****************************************************************
  // Packed-decimal digit check
  // ****************************************************************
  assign bcd_view = imm_wide_in ? imm_in
                                : {{HALF_W{1'b0}}, imm_in[HALF_W-1:0]};

  packed_decimal_check #(
    .DIGITS        (BCD_DIGITS)
  ) u_bcd_check (
    .value_in      (bcd_view),
    .digits_ok_out (bcd_ok)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    ip_nxt         = ip_r;
    or_nxt         = or_r;
    done_nxt       = 1'b0;
    addr_valid_nxt = 1'b0;
    addr_nxt       = addr_r;
    data_nxt       = data_r;
    imm_err_nxt    = 1'b0;
    if (req_in) begin
      done_nxt = 1'b1;
      unique case (mode_in)
        MODE_RD_IP: begin
          data_nxt = DATA_W'(ptr);
        end
        MODE_RD_OR: begin
          data_nxt = DATA_W'(or_r[or_sel_in]);
        end
        MODE_WR_IP: begin
          ip_nxt[ip_sel_in] = wdata_in;
        end
        MODE_WR_OR: begin
          or_nxt[or_sel_in] = wdata_in;
        end
        MODE_LOAD_ADDR: begin
          ip_nxt[ip_sel_in] = location_addr_in;
        end
        MODE_IND: begin
          addr_nxt       = ptr;
          addr_valid_nxt = 1'b1;
        end
        MODE_IND_CONST: begin
          addr_nxt       = ptr + const_ext;
          addr_valid_nxt = 1'b1;
        end
        MODE_IND_OR: begin
          addr_nxt       = ptr + or_r[or_sel_in];
          addr_valid_nxt = 1'b1;
        end
        MODE_POST_INC1: begin
          addr_nxt          = ptr;
          addr_valid_nxt    = 1'b1;
          ip_nxt[ip_sel_in] = ptr + step_one;
        end
        MODE_POST_INC2: begin
          addr_nxt          = ptr;
          addr_valid_nxt    = 1'b1;
          ip_nxt[ip_sel_in] = ptr + step_two;
        end
        MODE_PRE_DEC1: begin
          addr_nxt          = ptr - step_one;
          addr_valid_nxt    = 1'b1;
          ip_nxt[ip_sel_in] = ptr - step_one;
        end
        MODE_PRE_DEC2: begin
          addr_nxt          = ptr - step_two;
          addr_valid_nxt    = 1'b1;
          ip_nxt[ip_sel_in] = ptr - step_two;
        end
        MODE_IMM: begin
          unique case (imm_form_in)
            IMM_SDEC: begin
              data_nxt = imm_wide_in ? imm_in
                : {{HALF_W{imm_in[HALF_W-1]}}, imm_in[HALF_W-1:0]};
            end
            IMM_PACKED: begin
              data_nxt    = bcd_view;
              imm_err_nxt = ~bcd_ok;
            end
            default: begin
              data_nxt = bcd_view;
            end
          endcase
        end
        default: begin
          done_nxt = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        ip_r[i] <= ADDR_W'(PTR_RST);
        or_r[i] <= ADDR_W'(PTR_RST);
      end
      done_r       <= 1'b0;
      addr_valid_r <= 1'b0;
      addr_r       <= ADDR_W'(PTR_RST);
      data_r       <= DATA_RST;
      imm_err_r    <= 1'b0;
    end else begin
      ip_r         <= ip_nxt;
      or_r         <= or_nxt;
      done_r       <= done_nxt;
      addr_valid_r <= addr_valid_nxt;
      addr_r       <= addr_nxt;
      data_r       <= data_nxt;
      imm_err_r    <= imm_err_nxt;
    end
  end

  assign done_out       = done_r;
  assign addr_valid_out = addr_valid_r;
  assign addr_out       = addr_r;
  assign data_out       = data_r;
  assign imm_err_out    = imm_err_r;

endmodule

// >>> oag_props.sv
// Checker for the operand address generator, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module oag_props
  import operand_addr_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic              sys_clk_in,
  input wire logic              rst_n_in,
  input wire logic              req_in,
  input wire logic [3:0]        mode_in,
  input wire logic [3:0]        ip_sel_in,
  input wire logic [1:0]        imm_form_in,
  input wire logic              imm_wide_in,
  input wire logic [31:0]       imm_in,
  input wire logic              done_out,
  input wire logic              addr_valid_out,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [31:0]       data_out,
  input wire logic              imm_err_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic ind;
  logic imm;
  logic bad;
  always_comb begin
    bad = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if ((imm_wide_in || i < 4) && imm_in[4*i+:4] > 4'h9) begin
        bad = 1'b1;
      end
    end
  end
  assign ind = req_in && mode_in >= MODE_IND && mode_in <= MODE_PRE_DEC2;
  assign imm = req_in && mode_in == MODE_IMM;
  // ****
  // Pointer step then read-back of the same pointer
  // ****
  sequence s_inc1;
    req_in && mode_in == MODE_POST_INC1 ##1
    req_in && mode_in == MODE_RD_IP && ip_sel_in == $past(ip_sel_in);
  endsequence
  sequence s_dec2;
    req_in && mode_in == MODE_PRE_DEC2 ##1
    req_in && mode_in == MODE_RD_IP && ip_sel_in == $past(ip_sel_in);
  endsequence
  chk_done_pulse: assert property (req_in |=> done_out)
    else $error("no done after request");
  chk_valid_ind: assert property (ind |=> addr_valid_out)
    else $error("no address strobe after indirect request");
  chk_addr_hold: assert property (!ind |=> $stable(addr_out))
    else $error("address moved without indirect request");
  chk_imm_err: assert property (imm && imm_form_in == IMM_PACKED
    |=> imm_err_out == $past(bad)) else $error("digit flag wrong");
  chk_imm_wide: assert property (imm && imm_wide_in
    |=> data_out == $past(imm_in)) else $error("wide constant wrong");
  chk_imm_sext: assert property (imm && !imm_wide_in
    && imm_form_in == IMM_SDEC |=> data_out ==
    {{16{$past(imm_in[15])}}, $past(imm_in[15:0])})
    else $error("signed constant not extended");
  chk_inc_step: assert property (s_inc1
    |=> data_out[ADDR_W-1:0] == addr_out + 1'b1)
    else $error("post increment step wrong");
  chk_dec_step: assert property (s_dec2
    |=> data_out[ADDR_W-1:0] == addr_out)
    else $error("decremented address not used");
endmodule

// >>> seq_model.sv
// Sequencer model: presents one operand request per clock edge.
// Assumes the generator samples every field at the rising edge.
`timescale 1ns/1ps
module seq_model (
  input  wire logic   sys_clk_in,
  output logic        req_out = 1'b0,
  output logic [3:0]  mode_out = 4'h0,
  output logic [3:0]  ip_out = 4'h0,
  output logic [3:0]  or_out = 4'h0,
  output logic [31:0] val_out = 32'h0,
  output logic [1:0]  form_out = 2'h0,
  output logic        wide_out = 1'b0
);
  task automatic issue(input logic [3:0] m, s, o, input logic [31:0] v,
                       input logic [1:0] f, input logic w);
    @(posedge sys_clk_in);
    req_out <= 1'b1;
    mode_out <= m;
    ip_out <= s;
    or_out <= o;
    val_out <= v;
    form_out <= f;
    wide_out <= w;
  endtask
  // Release shows junk on the value field only; the other fields keep the last value
  task automatic idle;
    @(posedge sys_clk_in);
    req_out <= 1'b0;
    val_out <= ~val_out;
  endtask
endmodule

// >>> testbench.sv
// Testbench: drives the generator through the sequencer model and
// compares its answers with values worked out here.
`timescale 1ns/1ps
module testbench;
  import operand_addr_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_out, wide_out, done_out, addr_valid_out, imm_err_out;
  logic [3:0] mode_out, ip_out, or_out;
  logic [1:0] form_out;
  logic [31:0] val_out, addr_out, data_out;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  seq_model seq_model_inst (.sys_clk_in, .req_out, .mode_out, .ip_out,
    .or_out, .val_out, .form_out, .wide_out);
  operand_address_generator operand_address_generator_inst (
    .sys_clk_in, .rst_n_in, .req_in(req_out), .mode_in(mode_out),
    .ip_sel_in(ip_out), .or_sel_in(or_out), .const_off_in(val_out[11:0]),
    .location_addr_in(val_out), .wdata_in(val_out), .imm_in(val_out),
    .imm_form_in(form_out), .imm_wide_in(wide_out), .done_out,
    .addr_valid_out, .addr_out, .data_out, .imm_err_out);
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****
  // Helpers and scenarios
  // ****
  task automatic op(logic [3:0] m, logic [3:0] s, logic [31:0] v);
    seq_model_inst.issue(m, s, s, v, IMM_UBIN, 1'b0);
  endtask
  task automatic fin;
    seq_model_inst.idle();
    #1;
  endtask
  task automatic rd(logic [3:0] m, logic [3:0] s, logic [31:0] exp);
    op(m, s, 32'h0);
    fin();
    chk(data_out, exp);
    chk({31'h0, done_out}, 32'h1);
  endtask
  task automatic ind(logic [3:0] m, s, o, logic [31:0] v, exp);
    seq_model_inst.issue(m, s, o, v, IMM_UBIN, 1'b0);
    fin();
    chk(addr_out, exp);
    chk({31'h0, addr_valid_out}, 32'h1);
  endtask
  task automatic imm(logic [1:0] f, logic w, logic [31:0] v, exp,
                     logic err);
    seq_model_inst.issue(MODE_IMM, 4'h0, 4'h0, v, f, w);
    fin();
    chk(data_out, exp);
    chk({31'h0, imm_err_out}, {31'h0, err});
  endtask
  task automatic t_regs;
    rd(MODE_RD_IP, 4'h3, 32'h0);
    for (int i = 0; i < 16; i++) begin
      op(MODE_WR_IP, 4'(i), 32'h100 * i + 32'h1);
      op(MODE_WR_OR, 4'(i), 32'hFFFF_FFF0 + i);
    end
    for (int i = 0; i < 16; i++) begin
      rd(MODE_RD_IP, 4'(i), 32'h100 * i + 32'h1);
      rd(MODE_RD_OR, 4'(i), 32'hFFFF_FFF0 + i);
    end
  endtask
  task automatic t_ind;
    op(MODE_LOAD_ADDR, 4'h5, 32'h0000_1000);
    fin();
    chk({31'h0, addr_valid_out}, 32'h0);
    rd(MODE_RD_IP, 4'h5, 32'h0000_1000);
    ind(MODE_IND, 4'h5, 4'h0, 32'h0, 32'h1000);
    ind(MODE_IND_CONST, 4'h5, 4'h0, 32'h800, 32'h0800);
    ind(MODE_IND_CONST, 4'h5, 4'h0, 32'h7FF, 32'h17FF);
    ind(MODE_IND_OR, 4'h5, 4'h2, 32'h0, 32'h0FF2);
  endtask
  task automatic t_steps;
    op(MODE_WR_IP, 4'h7, 32'h20);
    op(MODE_POST_INC2, 4'h7, 32'h0);
    op(MODE_POST_INC1, 4'h7, 32'h0);
    #1;
    chk(addr_out, 32'h20);
    rd(MODE_RD_IP, 4'h7, 32'h23);
    chk(addr_out, 32'h22);
    op(MODE_IND, 4'h7, 32'h0);
    op(MODE_PRE_DEC1, 4'h7, 32'h0);
    op(MODE_PRE_DEC2, 4'h7, 32'h0);
    #1;
    chk(addr_out, 32'h22);
    rd(MODE_RD_IP, 4'h7, 32'h20);
    chk(addr_out, 32'h20);
  endtask
  task automatic t_imm;
    imm(IMM_UBIN, 1'b0, 32'hABCD_8001, 32'h0000_8001, 1'b0);
    imm(IMM_SDEC, 1'b0, 32'hABCD_8001, 32'hFFFF_8001, 1'b0);
    imm(IMM_UDEC, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0);
    imm(IMM_PACKED, 1'b0, 32'hAAAA_9999, 32'h0000_9999, 1'b0);
    imm(IMM_PACKED, 1'b0, 32'h0000_00A0, 32'h0000_00A0, 1'b1);
    imm(IMM_PACKED, 1'b1, 32'hA000_0000, 32'hA000_0000, 1'b1);
    imm(IMM_PACKED, 1'b1, 32'h9999_9999, 32'h9999_9999, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_ind();
    t_steps();
    t_imm();
    tally_and_finish();
  end
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind operand_address_generator oag_props #(.ADDR_W(ADDR_W)) oag_props_inst (
  .sys_clk_in, .rst_n_in, .req_in, .mode_in, .ip_sel_in, .imm_form_in,
  .imm_wide_in, .imm_in, .done_out, .addr_valid_out, .addr_out,
  .data_out, .imm_err_out);
